// ---- rtl/tsp_pkg.sv ----
// Purpose: Shared constants and types for the thermal sensor bus port.
// Assumes: Core clock of 20 MHz; the 9-bit values sit left-justified in 16-bit words.
// Notes:   Conversion and power-up window times are plain defaults for the model.
package tsp_pkg;
   localparam logic [7:0] PTR_TEMP   = 8'h00;
   localparam logic [7:0] PTR_SETUP  = 8'h01;
   localparam logic [7:0] PTR_LOW    = 8'h02;
   localparam logic [7:0] PTR_HIGH   = 8'h03;
   localparam logic [3:0] ADDR_UPPER = 4'h9;
   localparam int SB_POWER_DOWN_BIT = 0;
   localparam int SB_MODE = 1;
   localparam int SB_POL  = 2;
   localparam int SB_FQ   = 3;
   localparam int SB_ZONE = 5;
   localparam int SB_MASK = 6;
   localparam int W_MSB   = 15;
   localparam int W_LSB   = 7;
   localparam logic [6:0]  SETUP_RST  = 7'h00;
   localparam logic [15:0] HIGH_RST   = 16'h5000;
   localparam logic [15:0] LOW_RST    = 16'h4b00;
   localparam logic [8:0]  TEMP_RST   = 9'h000;
   localparam logic [8:0]  DIODE_FULL = 9'h0ff;
   localparam int MCLK_NS   = 50;
   localparam int T_CONV_NS = 100000;
   localparam int T_POR_NS  = 20000;
   localparam int CONV_CYC  = (T_CONV_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int POR_CYC   = (T_POR_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int CNT_W     = 13;
   localparam logic [3:0] BITS_BYTE = 4'h8;

   typedef struct packed {
      logic [6:0]  setup;
      logic [15:0] low;
      logic [15:0] high;
   } tsp_cfg_t;

   typedef struct packed {
      logic [8:0] temp;
      logic       flag;
      logic [2:0] addr_lo;
      logic       addr_ok;
   } tsp_stat_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0, ST_ADDR = 4'h1, ST_AACK = 4'h3, ST_CMD  = 4'h2,
      ST_CACK = 4'h6, ST_WDAT = 4'h7, ST_WACK = 4'h5, ST_RDAT = 4'h4,
      ST_RACK = 4'hc
   } tsp_state_t;

   function automatic logic [2:0] fq_depth(input logic [1:0] code);
      case (code)
         2'b00:   fq_depth = 3'h1;
         2'b01:   fq_depth = 3'h2;
         2'b10:   fq_depth = 3'h4;
         default: fq_depth = 3'h6;
      endcase
   endfunction
endpackage

// ---- rtl/tsp_top.sv ----
// Purpose: Two-wire client port, register file and conversion control of a temperature supervisor.
// Assumes: LINK_CLK_I oversamples the bus; temperature samples arrive on MCLK_I.
// Notes:   Bus front end and registers on LINK_CLK_I, converter and alert logic on MCLK_I.
// Summary of operation
// - Write: address with write bit, command byte, then one or two data bytes.
// - Read: address, command, repeated start, read address, then data shifted out.
// - Read address alone returns data from the last stored pointer.
// - Each command byte is stored in a write-only pointer.
// - Pointer 00h-03h pick temperature, setup, low and high thresholds.
// - Setup register is one byte, served by single-byte transfers.
// - Temperature and thresholds move as 16-bit words.
// - Temperatures are 9-bit two's complement, half degree steps, sign in D8.
// - Value is left-justified; the seven low bits are undefined.
// - A one-byte read returns the word's upper byte.
// - Out of shutdown, conversions run back to back.
// - Bus access aborts conversion; new one starts when access ends.
// - Remote diode conversion lasts twice the on-chip conversion.
// - Address pins sampled once at power-up into low address bits.
// - Power-up defaults: running, local, comparator, active low, depth one, thresholds 80/75.
// - Shared pin pulled low during power-up window; diode reads as zero.
// - Shutdown stops conversions; registers stay accessible.
// - Shutdown in comparator behaviour leaves the alert level alone.
// - Shutdown in interrupt behaviour releases alert and clears the event flag.
// - Shutdown keeps the record of the last event direction.
// - No diode fault during shutdown; resumes after one completed conversion.
// - Client address is fixed upper pattern plus pins, 48h to 4Fh.
// - Reading any register clears the event flag; this releases the alert only in interrupt behaviour.
// - Setup filter field needs 1, 2, 4 or 6 qualifying conversions.
`timescale 1ns/100ps
module tsp_top
(
   input  wire logic       MCLK_I,
   input  wire logic       LINK_CLK_I,
   input  wire logic       RST_B_I,
   input  wire logic       SCL_I,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_O,
   input  wire logic       ADDR2_DIODE_PIN_I,
   input  wire logic       ADDR_PIN_MID_I,
   input  wire logic       ADDR_PIN_LOW_I,
   output logic            ADDR2_PD_O,
   input  wire logic [8:0] TEMP_LOCAL_I,
   input  wire logic [8:0] TEMP_REMOTE_I,
   input  wire logic       DIODE_FAULT_I,
   output logic            ALERT_OUTPUT_O,
   output logic            ALERT_OUTPUT_OE_O
);
   localparam int CNT_W = tsp_pkg::CNT_W;
   logic              rs1_reg, rst_n, lr1_reg, lrst_n;
   logic [2:0]        ap1_reg, ap2_reg;
   logic [CNT_W-1:0]  por_cnt_reg, conv_cnt_reg, conv_lim;
   logic              por_done_reg;
   tsp_pkg::tsp_cfg_t cfg_c_reg, cfg_l_reg;
   tsp_pkg::tsp_stat_t stat_reg, stat_next, stat_l_reg;
   logic [2:0]        addr_lat_reg;
   logic              bz1_reg, bz2_reg, rt1_reg, rt2_reg, rt3_reg;
   logic              ct1_reg, ct2_reg, ct3_reg, st1_reg, st2_reg, st3_reg;
   logic              st_tgl_reg, busy_reg, rd_tgl_reg, cfg_tgl_reg;
   logic [8:0]        temp_reg, smp;
   logic [2:0]        over_cnt_reg, under_cnt_reg, depth;
   logic              last_over_reg, flag_reg, woke_reg, mode_d_reg, power_down_bit_d_reg;
   logic              run, done, over, under, q_over, q_under, ev, rd_ev, cfg_ev;
   logic              power_down_bit, mode, zone, asrt;
   logic              sc1_reg, sc2_reg, scp_reg, sd1_reg, sd2_reg, sdp_reg;
   logic              rise, fall, start, stop;
   tsp_pkg::tsp_state_t st_reg;
   logic [3:0]        cnt_reg;
   logic [7:0]        shf_reg, ptr_reg, hold_reg, rbyte, rbyte_lo;
   logic [1:0]        bidx_reg;
   logic              rw_reg, sda_oe_reg;

   function automatic logic [7:0] rd_byte(input logic [7:0] ptr, input logic idx,
                                          input tsp_pkg::tsp_cfg_t c,
                                          input tsp_pkg::tsp_stat_t s);
      rd_byte = 8'h00;
      case (ptr)
         tsp_pkg::PTR_TEMP:  rd_byte = idx ? {s.temp[0], 7'h00} : s.temp[8:1];
         tsp_pkg::PTR_SETUP: rd_byte = {s.flag, c.setup};
         tsp_pkg::PTR_LOW:   rd_byte = idx ? c.low[7:0] : c.low[15:8];
         tsp_pkg::PTR_HIGH:  rd_byte = idx ? c.high[7:0] : c.high[15:8];
         default:            rd_byte = 8'h00;
      endcase
   endfunction

   // Both domains leave reset through their own two-flop release.
   always_ff @(posedge MCLK_I or negedge RST_B_I)
      if (!RST_B_I)
      begin
         rs1_reg <= 1'b0;
         rst_n   <= 1'b0;
      end
      else
      begin
         rs1_reg <= 1'b1;
         rst_n   <= rs1_reg;
      end

   always_ff @(posedge LINK_CLK_I or negedge RST_B_I)
      if (!RST_B_I)
      begin
         lr1_reg <= 1'b0;
         lrst_n  <= 1'b0;
      end
      else
      begin
         lr1_reg <= 1'b1;
         lrst_n  <= lr1_reg;
      end

   // Crossings into the core domain; the first flop of each feeds only the second.
   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         {ap1_reg, ap2_reg} <= 6'h00;
         {bz1_reg, bz2_reg, rt1_reg, rt2_reg, rt3_reg} <= 5'h00;
         {ct1_reg, ct2_reg, ct3_reg} <= 3'h0;
      end
      else
      begin
         ap1_reg <= {ADDR2_DIODE_PIN_I, ADDR_PIN_MID_I, ADDR_PIN_LOW_I};
         ap2_reg <= ap1_reg;
         bz1_reg <= busy_reg;
         bz2_reg <= bz1_reg;
         {rt1_reg, rt2_reg, rt3_reg} <= {rd_tgl_reg, rt1_reg, rt2_reg};
         {ct1_reg, ct2_reg, ct3_reg} <= {cfg_tgl_reg, ct1_reg, ct2_reg};
      end

   assign rd_ev  = rt2_reg ^ rt3_reg;
   assign cfg_ev = ct2_reg ^ ct3_reg;

   // The settings word is held still by the link until its toggle has been seen here.
   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         cfg_c_reg <= '{setup: tsp_pkg::SETUP_RST, low: tsp_pkg::LOW_RST,
                        high: tsp_pkg::HIGH_RST};
      end
      else if (cfg_ev)
         cfg_c_reg <= cfg_l_reg;

   assign power_down_bit  = cfg_c_reg.setup[tsp_pkg::SB_POWER_DOWN_BIT];
   assign mode  = cfg_c_reg.setup[tsp_pkg::SB_MODE];
   assign zone  = cfg_c_reg.setup[tsp_pkg::SB_ZONE];
   assign depth = tsp_pkg::fq_depth(cfg_c_reg.setup[tsp_pkg::SB_FQ +: 2]);

   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         por_cnt_reg  <= '0;
         por_done_reg <= 1'b0;
         ADDR2_PD_O   <= 1'b0;
         addr_lat_reg <= 3'h0;
      end
      else if (!por_done_reg)
      begin
         ADDR2_PD_O  <= 1'b1;
         por_cnt_reg <= por_cnt_reg + 1'b1;
         if (por_cnt_reg == CNT_W'(tsp_pkg::POR_CYC - 1))
         begin
            por_done_reg <= 1'b1;
            ADDR2_PD_O   <= 1'b0;
            addr_lat_reg <= ap2_reg;
         end
      end

   assign conv_lim = zone ? CNT_W'(2 * tsp_pkg::CONV_CYC - 1) : CNT_W'(tsp_pkg::CONV_CYC - 1);
   assign run  = por_done_reg && !power_down_bit && !bz2_reg;
   assign done = run && (conv_cnt_reg == conv_lim);

   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
         conv_cnt_reg <= '0;
      else if (!run || done)
         conv_cnt_reg <= '0;
      else
         conv_cnt_reg <= conv_cnt_reg + 1'b1;

   // fault seen only after a wake conversion
   assign smp = !zone ? TEMP_LOCAL_I :
                (DIODE_FAULT_I && woke_reg) ? tsp_pkg::DIODE_FULL : TEMP_REMOTE_I;
   assign over  = $signed(smp) > $signed(cfg_c_reg.high[tsp_pkg::W_MSB:tsp_pkg::W_LSB]);
   assign under = $signed(smp) < $signed(cfg_c_reg.low[tsp_pkg::W_MSB:tsp_pkg::W_LSB]);
   assign q_over  = over && (over_cnt_reg + 3'h1 >= depth);
   assign q_under = under && (under_cnt_reg + 3'h1 >= depth);
   assign ev = done && ((q_over && !last_over_reg) || (q_under && last_over_reg));

   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         temp_reg      <= tsp_pkg::TEMP_RST;
         over_cnt_reg  <= 3'h0;
         under_cnt_reg <= 3'h0;
         woke_reg      <= 1'b0;
      end
      else
      begin
         if (power_down_bit)
            woke_reg <= 1'b0;
         else if (done)
            woke_reg <= 1'b1;
         if (done)
         begin
            temp_reg      <= smp;
            over_cnt_reg  <= (over && !q_over) ? over_cnt_reg + 3'h1 : 3'h0;
            under_cnt_reg <= (under && !q_under) ? under_cnt_reg + 3'h1 : 3'h0;
         end
      end

   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         last_over_reg <= 1'b0;
         mode_d_reg    <= 1'b0;
         power_down_bit_d_reg    <= 1'b0;
      end
      else
      begin
         mode_d_reg <= mode;
         power_down_bit_d_reg <= power_down_bit;
         if (ev)
            last_over_reg <= !last_over_reg;
         else if (mode && !mode_d_reg)
            last_over_reg <= 1'b0;
      end

   // An event in the clearing cycle still sets the flag.
   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
         flag_reg <= 1'b0;
      else if (ev)
         flag_reg <= 1'b1;
      else if (rd_ev)
         flag_reg <= 1'b0;
      else if (power_down_bit && !power_down_bit_d_reg && mode)
         flag_reg <= 1'b0;

   assign asrt = mode ? flag_reg : last_over_reg;

   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         ALERT_OUTPUT_O    <= 1'b0;
         ALERT_OUTPUT_OE_O <= 1'b0;
      end
      else
      begin
         ALERT_OUTPUT_O    <= 1'b0;
         ALERT_OUTPUT_OE_O <= !cfg_c_reg.setup[tsp_pkg::SB_MASK] &&
                              (asrt ^ cfg_c_reg.setup[tsp_pkg::SB_POL]);
      end

   assign stat_next = '{temp: temp_reg, flag: flag_reg, addr_lo: addr_lat_reg,
                        addr_ok: por_done_reg};

   // Status is re-sent whenever it changes; it then holds for at least one core cycle.
   always_ff @(posedge MCLK_I or negedge rst_n)
      if (!rst_n)
      begin
         stat_reg   <= '0;
         st_tgl_reg <= 1'b0;
      end
      else
      begin
         stat_reg   <= stat_next;
         st_tgl_reg <= st_tgl_reg ^ (stat_next != stat_reg);
      end

   // Link side synchronisers.
   always_ff @(posedge LINK_CLK_I or negedge lrst_n)
      if (!lrst_n)
      begin
         {sc1_reg, sc2_reg, scp_reg, sd1_reg, sd2_reg, sdp_reg} <= 6'h3f;
         {st1_reg, st2_reg, st3_reg} <= 3'h0;
         stat_l_reg <= '0;
      end
      else
      begin
         {sc1_reg, sc2_reg, scp_reg} <= {SCL_I, sc1_reg, sc2_reg};
         {sd1_reg, sd2_reg, sdp_reg} <= {SDA_I, sd1_reg, sd2_reg};
         {st1_reg, st2_reg, st3_reg} <= {st_tgl_reg, st1_reg, st2_reg};
         if (st2_reg ^ st3_reg)
            stat_l_reg <= stat_reg;
      end

   assign rise  = sc2_reg && !scp_reg;
   assign fall  = !sc2_reg && scp_reg;
   assign start = sc2_reg && scp_reg && sdp_reg && !sd2_reg;
   assign stop  = sc2_reg && scp_reg && !sdp_reg && sd2_reg;
   assign rbyte = rd_byte(ptr_reg, bidx_reg[0], cfg_l_reg, stat_l_reg);
   assign rbyte_lo = rd_byte(ptr_reg, 1'b1, cfg_l_reg, stat_l_reg);

   always_ff @(posedge LINK_CLK_I or negedge lrst_n)
      if (!lrst_n)
      begin
         st_reg      <= tsp_pkg::ST_IDLE;
         cnt_reg     <= 4'h0;
         shf_reg     <= 8'h00;
         ptr_reg     <= tsp_pkg::PTR_TEMP;
         hold_reg    <= 8'h00;
         bidx_reg    <= 2'h0;
         rw_reg      <= 1'b0;
         sda_oe_reg  <= 1'b0;
         busy_reg    <= 1'b0;
         rd_tgl_reg  <= 1'b0;
         cfg_tgl_reg <= 1'b0;
         cfg_l_reg   <= '{setup: tsp_pkg::SETUP_RST, low: tsp_pkg::LOW_RST,
                          high: tsp_pkg::HIGH_RST};
      end
      else if (start)
      begin
         st_reg     <= tsp_pkg::ST_ADDR;
         cnt_reg    <= 4'h0;
         sda_oe_reg <= 1'b0;
      end
      else if (stop)
      begin
         st_reg     <= tsp_pkg::ST_IDLE;
         sda_oe_reg <= 1'b0;
         busy_reg   <= 1'b0;
      end
      else if (rise)
      begin
         if (st_reg == tsp_pkg::ST_RACK)
            shf_reg[0] <= sd2_reg;
         else if (st_reg inside {tsp_pkg::ST_ADDR, tsp_pkg::ST_CMD, tsp_pkg::ST_WDAT})
            shf_reg <= {shf_reg[6:0], sd2_reg};
         if (st_reg inside {tsp_pkg::ST_ADDR, tsp_pkg::ST_CMD, tsp_pkg::ST_WDAT,
                            tsp_pkg::ST_RDAT})
            cnt_reg <= cnt_reg + 4'h1;
      end
      else if (fall)
      begin
         unique case (st_reg)
            tsp_pkg::ST_IDLE: ;
            tsp_pkg::ST_ADDR:
               if (cnt_reg == tsp_pkg::BITS_BYTE)
               begin
                  if (stat_l_reg.addr_ok &&
                      shf_reg[7:1] == {tsp_pkg::ADDR_UPPER, stat_l_reg.addr_lo})
                  begin
                     st_reg     <= tsp_pkg::ST_AACK;
                     sda_oe_reg <= 1'b1;
                     busy_reg   <= 1'b1;
                     rw_reg     <= shf_reg[0];
                     bidx_reg   <= 2'h0;
                  end
                  else
                  begin
                     st_reg   <= tsp_pkg::ST_IDLE;
                     busy_reg <= 1'b0;
                  end
               end
            tsp_pkg::ST_AACK:
            begin
               cnt_reg <= 4'h0;
               if (rw_reg)
               begin
                  st_reg     <= tsp_pkg::ST_RDAT;
                  shf_reg    <= rbyte;
                  sda_oe_reg <= !rbyte[7];
               end
               else
               begin
                  st_reg     <= tsp_pkg::ST_CMD;
                  sda_oe_reg <= 1'b0;
               end
            end
            tsp_pkg::ST_CMD:
               if (cnt_reg == tsp_pkg::BITS_BYTE)
               begin
                  ptr_reg    <= shf_reg;
                  st_reg     <= tsp_pkg::ST_CACK;
                  sda_oe_reg <= 1'b1;
               end
            tsp_pkg::ST_CACK, tsp_pkg::ST_WACK:
            begin
               st_reg     <= tsp_pkg::ST_WDAT;
               cnt_reg    <= 4'h0;
               sda_oe_reg <= 1'b0;
            end
            tsp_pkg::ST_WDAT:
               if (cnt_reg == tsp_pkg::BITS_BYTE)
               begin
                  st_reg     <= tsp_pkg::ST_WACK;
                  sda_oe_reg <= 1'b1;
                  if (bidx_reg != 2'h2)
                     bidx_reg <= bidx_reg + 2'h1;
                  if (ptr_reg == tsp_pkg::PTR_SETUP && bidx_reg == 2'h0)
                  begin
                     cfg_l_reg.setup <= shf_reg[6:0];
                     cfg_tgl_reg     <= !cfg_tgl_reg;
                  end
                  else if (bidx_reg == 2'h0)
                     hold_reg <= shf_reg;
                  else if (bidx_reg == 2'h1 &&
                           (ptr_reg == tsp_pkg::PTR_LOW || ptr_reg == tsp_pkg::PTR_HIGH))
                  begin
                     if (ptr_reg == tsp_pkg::PTR_LOW)
                        cfg_l_reg.low <= {hold_reg, shf_reg};
                     else
                        cfg_l_reg.high <= {hold_reg, shf_reg};
                     cfg_tgl_reg <= !cfg_tgl_reg;
                  end
               end
            tsp_pkg::ST_RDAT:
               if (cnt_reg == tsp_pkg::BITS_BYTE)
               begin
                  st_reg     <= tsp_pkg::ST_RACK;
                  sda_oe_reg <= 1'b0;
                  // read clears flag
                  // The clear waits for the first byte, so a status poll still sees the flag.
                  if (bidx_reg == 2'h0)
                     rd_tgl_reg <= !rd_tgl_reg;
               end
               else
               begin
                  shf_reg    <= {shf_reg[6:0], 1'b0};
                  sda_oe_reg <= !shf_reg[6];
               end
            tsp_pkg::ST_RACK:
               if (!shf_reg[0])
               begin
                  st_reg     <= tsp_pkg::ST_RDAT;
                  cnt_reg    <= 4'h0;
                  shf_reg    <= rbyte_lo;
                  sda_oe_reg <= !rbyte_lo[7];
                  bidx_reg   <= 2'h1;
               end
               else
                  st_reg <= tsp_pkg::ST_IDLE;
            default:
               st_reg <= tsp_pkg::ST_IDLE;
         endcase
      end

   always_ff @(posedge LINK_CLK_I or negedge lrst_n)
      if (!lrst_n)
      begin
         SDA_O    <= 1'b0;
         SDA_OE_O <= 1'b0;
      end
      else
      begin
         SDA_O    <= 1'b0;
         SDA_OE_O <= sda_oe_reg;
      end
endmodule

// ---- dv/tsp_chk.sv ----
// Purpose: Port-level checks of the bus, alert and address pins of tsp_top.
// Assumes: Sees only top-level ports; both clock domains share RST_B_I.
// Notes:   The power-up window length comes from the package.
`timescale 1ns/100ps
module tsp_chk
(
   input  wire logic MCLK_I,
   input  wire logic LINK_CLK_I,
   input  wire logic RST_B_I,
   input  wire logic SCL_I,
   input  wire logic SDA_O,
   input  wire logic SDA_OE_O,
   input  wire logic ADDR2_PD_O,
   input  wire logic ALERT_OUTPUT_O,
   input  wire logic ALERT_OUTPUT_OE_O
);
   localparam int PLO = tsp_pkg::POR_CYC - 1;
   localparam int PHI = tsp_pkg::POR_CYC + 1;
   logic [9:0] pd_cnt_reg;
   logic       pd_done_reg;
   always_ff @(posedge MCLK_I or negedge RST_B_I)
      if (!RST_B_I)
         pd_cnt_reg <= 10'h000;
      else if (ADDR2_PD_O)
         pd_cnt_reg <= pd_cnt_reg + 10'h001;
   always_ff @(posedge MCLK_I or negedge RST_B_I)
      if (!RST_B_I)
         pd_done_reg <= 1'b0;
      else if ($fell(ADDR2_PD_O))
         pd_done_reg <= 1'b1;
   sequence s_alert_quiet;
      !ALERT_OUTPUT_OE_O [*3];
   endsequence
   a_sda_open_drain: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I)
      SDA_OE_O |-> !SDA_O) else $error("data pin driven high");
   a_ack_scl_low: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I)
      $rose(SDA_OE_O) |-> !SCL_I) else $error("data pulled while clock high");
   a_data_stable_high: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I)
      SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O)) else $error("data moved in clock high");
   a_pd_window_len: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      $fell(ADDR2_PD_O) |-> int'(pd_cnt_reg) inside {[PLO:PHI]})
      else $error("pull-down window length wrong");
   a_pd_only_once: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      pd_done_reg |-> !ADDR2_PD_O) else $error("pull-down came back");
   a_no_ack_early: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      ADDR2_PD_O |-> !SDA_OE_O) else $error("bus answered before address latch");
   a_alert_open_drain: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      ALERT_OUTPUT_OE_O |-> !ALERT_OUTPUT_O) else $error("alert pin driven high");
   a_alert_rst_quiet: assert property (@(posedge MCLK_I) disable iff (!RST_B_I)
      $rose(RST_B_I) |-> s_alert_quiet) else $error("alert active after reset");
endmodule
bind tsp_top tsp_chk i_chk (.MCLK_I(MCLK_I), .LINK_CLK_I(LINK_CLK_I), .RST_B_I(RST_B_I),
   .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .ADDR2_PD_O(ADDR2_PD_O),
   .ALERT_OUTPUT_O(ALERT_OUTPUT_O), .ALERT_OUTPUT_OE_O(ALERT_OUTPUT_OE_O));

// ---- dv/tsp_host.sv ----
// Purpose: Behavioural two-wire bus host for the thermal sensor port bench.
// Assumes: sda_i is the resolved open-drain wire with its pull-up.
// Notes:   A bit cell is ten core cycles; SCL rests high between frames.
`timescale 1ns/100ps
module tsp_host
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_oe_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   task automatic hw(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // data changes one cycle after SCL falls, never with it.
   task automatic bit_io(input logic b, output logic r);
      hw(1);
      sda_oe_o = ~b;
      hw(4);
      scl_o = 1'b1;
      hw(3);
      r = sda_i;
      hw(2);
      scl_o = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] d, output logic [7:0] q);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
   endtask
   // start, repeated start (0,1,1) or stop (1,0,0).
   task automatic cond(input logic pre, input logic post, input logic end_low);
      hw(1);
      sda_oe_o = pre;
      hw(4);
      scl_o = 1'b1;
      hw(5);
      sda_oe_o = post;
      hw(5);
      if (end_low)
         scl_o = 1'b0;
   endtask
endmodule

// ---- dv/tsp_top_tb.sv ----
// Purpose: Self-checking bench for tsp_top through its two-wire port.
// Assumes: A diode sits on the shared address pin; the other pins are tied high.
// Notes:   Conversion waits use the 2000-cycle on-chip sample period.
`timescale 1ns/100ps
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((e) !== (g)) \
      begin \
         $display("mismatch %s exp %h got %h", nm, e, g); \
         fails++; \
      end \
   end
module tsp_top_tb;
   localparam logic [6:0] DEV = {tsp_pkg::ADDR_UPPER, 3'b011};
   logic mclk, lclk, rst_b, scl, host_oe, sda, dut_sda, dut_oe, pd, alert_oe;
   logic [8:0]  temp_l, temp_r;
   logic [15:0] d;
   logic        a;
   int          fails, checks_done, k;
   // The diode holds the shared pin low only while the pull-down is on.
   assign sda = ~(host_oe | dut_oe);
   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   initial
   begin
      lclk = 1'b0;
      #1.3;
      forever #3 lclk = ~lclk;
   end
   tsp_host i_host (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
   tsp_top i_dut (.MCLK_I(mclk), .LINK_CLK_I(lclk), .RST_B_I(rst_b), .SCL_I(scl),
      .SDA_I(sda), .SDA_O(dut_sda), .SDA_OE_O(dut_oe), .ADDR2_DIODE_PIN_I(~pd),
      .ADDR_PIN_MID_I(1'b1), .ADDR_PIN_LOW_I(1'b1), .ADDR2_PD_O(pd),
      .TEMP_LOCAL_I(temp_l), .TEMP_REMOTE_I(temp_r), .DIODE_FAULT_I(1'b0),
      .ALERT_OUTPUT_O(), .ALERT_OUTPUT_OE_O(alert_oe));
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic final_report();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic sb(input logic [7:0] v, output logic ack);
      logic [7:0] q;
      logic       r;
      i_host.byte_io(v, q);
      i_host.bit_io(1'b1, r);
      ack = ~r;
   endtask
   task automatic wr(input logic [7:0] p, input int n, input logic [15:0] v);
      logic [3:0] ak;
      ak = 4'hf;
      i_host.cond(1'b0, 1'b1, 1'b1);
      sb({DEV, 1'b0}, ak[0]);
      sb(p, ak[1]);
      if (n > 1)
         sb(v[15:8], ak[2]);
      sb(n > 1 ? v[7:0] : v[15:8], ak[3]);
      i_host.cond(1'b1, 1'b0, 1'b0);
      `CHK("write acks", 4'hf, ak)
   endtask
   task automatic rd(input logic [7:0] p, input logic rcv, input int n, output logic [15:0] v);
      logic ak, r;
      v = 16'h0000;
      if (!rcv)
      begin
         i_host.cond(1'b0, 1'b1, 1'b1);
         sb({DEV, 1'b0}, ak);
         sb(p, ak);
      end
      i_host.cond(1'b0, 1'b1, 1'b1);
      sb({DEV, 1'b1}, ak);
      i_host.byte_io(8'hff, v[15:8]);
      i_host.bit_io(n == 1, r);
      if (n > 1)
         i_host.byte_io(8'hff, v[7:0]);
      if (n > 1)
         i_host.bit_io(1'b1, r);
      i_host.cond(1'b1, 1'b0, 1'b0);
   endtask
   initial
   begin
      rst_b = 1'b0;
      temp_l = 9'h000;
      temp_r = 9'h032;
      fails = 0;
      checks_done = 0;
      cyc(4);
      rst_b = 1'b1;
      a = 1'b0;
      for (k = 0; k < 1000; k++)
      begin
         cyc(1);
         a = a | pd;
         if (a && !pd)
            break;
      end
      if (k == 1000)
      begin
         fails++;
         final_report();
      end
      cyc(10);
      i_host.cond(1'b0, 1'b1, 1'b1);
      sb({tsp_pkg::ADDR_UPPER, 3'b111, 1'b0}, a);
      i_host.cond(1'b1, 1'b0, 1'b0);
      `CHK("foreign address ack", 1'b0, a)
      rd(tsp_pkg::PTR_LOW, 1'b0, 2, d);
      `CHK("low default", 16'h4b00, d & 16'hff80)
      rd(tsp_pkg::PTR_HIGH, 1'b0, 2, d);
      `CHK("high default", 16'h5000, d & 16'hff80)
      rd(tsp_pkg::PTR_SETUP, 1'b0, 1, d);
      `CHK("setup default", 7'h00, d[14:8])
      wr(tsp_pkg::PTR_HIGH, 2, 16'h1980); // thresholds written as words
      rd(tsp_pkg::PTR_HIGH, 1'b0, 2, d);
      `CHK("high word", 16'h1980, d & 16'hff80)
      rd(tsp_pkg::PTR_HIGH, 1'b0, 1, d);
      `CHK("high byte", 8'h19, d[15:8])
      rd(8'h00, 1'b1, 1, d);
      `CHK("receive byte", 8'h19, d[15:8])
      wr(8'h04, 2, 16'hffff);
      rd(tsp_pkg::PTR_HIGH, 1'b0, 2, d);
      `CHK("high after reserved", 16'h1980, d & 16'hff80)
      temp_l = 9'h1ce;
      cyc(2100);
      rd(tsp_pkg::PTR_TEMP, 1'b0, 2, d);
      `CHK("negative temp word", 16'he700, d & 16'hff80)
      temp_l = 9'h0fa;
      cyc(1500);
      rd(8'h00, 1'b1, 1, d);
      `CHK("temp before period", 8'he7, d[15:8])
      cyc(1500);
      rd(8'h00, 1'b1, 1, d);
      `CHK("temp after abort", 8'he7, d[15:8])
      cyc(2100);
      `CHK("comparator alert", 1'b1, alert_oe)
      rd(8'h00, 1'b1, 2, d);
      `CHK("new temp word", 16'h7d00, d & 16'hff80)
      wr(tsp_pkg::PTR_SETUP, 1, 16'h0100);
      temp_l = 9'h000;
      cyc(2100);
      `CHK("alert in shutdown", 1'b1, alert_oe)
      rd(tsp_pkg::PTR_TEMP, 1'b0, 2, d);
      `CHK("temp frozen", 16'h7d00, d & 16'hff80)
      rd(tsp_pkg::PTR_SETUP, 1'b0, 1, d);
      `CHK("setup in shutdown", 7'h01, d[14:8])
      wr(tsp_pkg::PTR_SETUP, 1, 16'h0200); // interrupt mode, running
      temp_l = 9'h0fa;
      cyc(2100);
      `CHK("interrupt alert", 1'b1, alert_oe)
      rd(8'h00, 1'b1, 1, d);
      `CHK("status in setup", 8'h82, d[15:8])
      cyc(10);
      `CHK("alert after read", 1'b0, alert_oe)
      temp_l = 9'h000;
      cyc(2100);
      `CHK("under event alert", 1'b1, alert_oe)
      wr(tsp_pkg::PTR_SETUP, 1, 16'h0300); // shutdown in interrupt mode
      cyc(10);
      `CHK("alert released", 1'b0, alert_oe)
      wr(tsp_pkg::PTR_SETUP, 1, 16'h2000); // remote zone, comparator
      cyc(3000);
      rd(tsp_pkg::PTR_TEMP, 1'b0, 2, d);
      `CHK("remote not yet", 16'h0000, d & 16'hff80)
      cyc(4100);
      rd(8'h00, 1'b1, 2, d);
      `CHK("remote temp", 16'h1900, d & 16'hff80)
      final_report();
   end
endmodule
